// File: hdl/kbpi_top.sv
// Purpose : key pin interrupt unit with apb register access
// Assumes : pins asynchronous, apb and logic on i_mclk (20 MHz)
// Notes   : zero-wait apb slave, read data loaded in setup phase
//
// Notes on behaviour
// R1: eight pins, each with own enable
// R2: one bit picks edge or edge-plus-level
// R3: per-pin polarity picks falling/low or rising/high
// R4: falling edge is high then low sample
// R5: rising edge is low then high sample
// R6: edge needs deasserted level seen first
// R7: edge on enabled pin sets flag
// R8: flag with irq enable requests interrupt
// R9: writing one to acknowledge clears flag
// R10: level mode sets flag on asserted level
// R11: level mode clears only when all deasserted
// R12: asserted enabled pin keeps flag set
// R13: pull polarity: pullup at 0, pulldown at 1
// R14: spurious flag on first enable is tolerated
// R15: software masks, configures, acknowledges, then enables
// R16: acknowledge reads zero, flag writes ignored
// R17: unused status bits read zero
// R18: deep stop wake returns to reset state
// R19: pins pass a two-stage synchroniser
//
// The APB interface to the registers and the address map were chosen for this implementation.
`include "kbpi_defines.svh"
`default_nettype none

module kbpi_top
(
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_nrst,
  // apb slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`KBPI_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // key pins and power control
  input  wire logic [`KBPI_NPIN-1:0]   i_key_pin,
  input  wire logic                    i_stop_wake,
  // pull resistor controls
  output logic      [`KBPI_NPIN-1:0]   o_pull_up,
  output logic      [`KBPI_NPIN-1:0]   o_pull_down,
  // interrupt
  output logic                         o_irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // known register words; anything else answers with an error
  function automatic logic is_mapped(input logic [`KBPI_ADDR_W-1:0] a);
    is_mapped = (a == `KBPI_OFF_STATUS)   || (a == `KBPI_OFF_PIN_EN) ||
                (a == `KBPI_OFF_POLARITY) || (a == `KBPI_OFF_PULL_EN) ||
                (a == `KBPI_OFF_EV_STAT)  || (a == `KBPI_OFF_EV_CLR) ||
                (a == `KBPI_OFF_EV_EN);
  endfunction

  // read mux; write-only words and unused bits read zero
  function automatic logic [31:0] read_word(input logic [`KBPI_ADDR_W-1:0] a,
                                            input kbpi_pkg::kbpi_state_t s);
    read_word = 32'h0000_0000;
    unique case (a)
      `KBPI_OFF_STATUS:
      begin
        read_word[`KBPI_BIT_FLAG]   = s.flag;     // [R16] [R17]
        read_word[`KBPI_BIT_IRQ_EN] = s.irq_en;
        read_word[`KBPI_BIT_LEVEL]  = s.lvl_mode;
      end
      `KBPI_OFF_PIN_EN:   read_word[7:0] = s.pin_en;
      `KBPI_OFF_POLARITY: read_word[7:0] = s.pol;
      `KBPI_OFF_PULL_EN:  read_word[7:0] = s.pull_en;
      `KBPI_OFF_EV_STAT:  read_word[7:0] = s.ev_stat;
      `KBPI_OFF_EV_EN:    read_word[7:0] = s.ev_en;
      default:            read_word = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------------
  kbpi_pin_if pin_bus ();

  assign pin_bus.raw = i_key_pin;

  // metastability guard before any edge or level test
  kbpi_sync u_sync   // [R19]
  (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .pins   (pin_bus.snc)
  );

  // ----------------------------------------------------------------------
  // state and next state
  // ----------------------------------------------------------------------
  kbpi_pkg::kbpi_state_t st_q;
  kbpi_pkg::kbpi_state_t st_d;

  kbpi_pkg::kbpi_pins_t  asserted;
  kbpi_pkg::kbpi_pins_t  en_asserted;
  kbpi_pkg::kbpi_pins_t  edge_hit;
  logic                  wr_acc;
  logic                  rd_setup;
  logic                  ack_wr;
  logic                  clr_ok;
  logic                  flag_set;

  // asserted sense follows polarity: low when 0, high when 1
  assign asserted    = ~(pin_bus.sync ^ st_q.pol);                  // [R3]
  assign en_asserted = st_q.pin_en & asserted;                      // [R1]
  // one-cycle sample pair: deasserted last cycle, asserted now
  assign edge_hit    = st_q.pin_en & st_q.armed & ~st_q.prev_a
                       & asserted;                                  // [R4] [R5] [R6]
  // level mode also sets on any enabled pin held asserted
  assign flag_set    = (|edge_hit) | (st_q.lvl_mode & (|en_asserted)); // [R7] [R10]

  assign wr_acc   = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign ack_wr   = wr_acc && (i_paddr == `KBPI_OFF_STATUS)
                    && i_pwdata[`KBPI_BIT_ACK];                     // [R9]
  // level mode refuses the clear while an enabled pin is asserted
  assign clr_ok   = ack_wr & (~st_q.lvl_mode | ~(|en_asserted));    // [R11] [R12]

  // next state; a set in the clear cycle wins over the clear
  always_comb
  begin
    st_d        = st_q;
    st_d.prev_a = asserted;
    // arming drops while disabled, so a newly enabled pin waits for idle
    st_d.armed  = st_q.pin_en & (st_q.armed | ~asserted);           // [R6]
    st_d.flag   = flag_set | (st_q.flag & ~clr_ok);                 // [R9] [R11]
    st_d.ev_stat = edge_hit;
    if (wr_acc && (i_paddr == `KBPI_OFF_EV_CLR))
      st_d.ev_stat = edge_hit | (st_q.ev_stat & ~i_pwdata[7:0]);
    else
      st_d.ev_stat = edge_hit | st_q.ev_stat;
    if (wr_acc)
    begin
      unique case (i_paddr)
        `KBPI_OFF_STATUS:
        begin
          // flag bit is not writable, only acknowledged
          st_d.irq_en   = i_pwdata[`KBPI_BIT_IRQ_EN];               // [R16]
          st_d.lvl_mode = i_pwdata[`KBPI_BIT_LEVEL];                // [R2]
        end
        `KBPI_OFF_PIN_EN:   st_d.pin_en  = i_pwdata[7:0];           // [R1] [R14]
        `KBPI_OFF_POLARITY: st_d.pol     = i_pwdata[7:0];
        `KBPI_OFF_PULL_EN:  st_d.pull_en = i_pwdata[7:0];
        `KBPI_OFF_EV_EN:    st_d.ev_en   = i_pwdata[7:0];
        default:            st_d.ev_en   = st_q.ev_en;
      endcase
    end
    if (rd_setup)
      st_d.rdata = read_word(i_paddr, st_q);
    // deep stop wake drops every register back to reset
    if (i_stop_wake)
      st_d = '0;                                                    // [R18]
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  // zero-wait slave; error only in access phase of unmapped word
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);
  assign o_prdata  = st_q.rdata;

  // resistor sense follows polarity of an enabled pull
  assign o_pull_up   = st_q.pull_en & ~st_q.pol;                    // [R13]
  assign o_pull_down = st_q.pull_en & st_q.pol;                     // [R13]

  // key flag request plus enabled sticky edge events
  assign o_irq = (st_q.flag & st_q.irq_en) | (|(st_q.ev_stat & st_q.ev_en)); // [R8]

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  flag_on_edge_a: assert property ( // [R7]
    (|edge_hit) && !i_stop_wake |=> st_q.flag)
    else $error("edge did not set the flag");

  edge_needs_idle_a: assert property ( // [R6]
    edge_hit[0] |-> ($past(st_q.pin_en[0]) && !$past(asserted[0])))
    else $error("edge seen without idle level first");

  fall_detect_a: assert property ( // [R4]
    (!st_q.pol[0] && st_q.pin_en[0] && $past(st_q.pin_en[0]) && st_q.armed[0]
     && $past(pin_bus.sync[0]) && !pin_bus.sync[0] && !$past(i_stop_wake))
    |-> edge_hit[0])
    else $error("falling edge missed");

  rise_detect_a: assert property ( // [R5]
    (st_q.pol[1] && st_q.pin_en[1] && $past(st_q.pin_en[1]) && st_q.armed[1]
     && !$past(pin_bus.sync[1]) && pin_bus.sync[1] && !$past(i_stop_wake))
    |-> edge_hit[1])
    else $error("rising edge missed");

  ack_clears_a: assert property ( // [R9]
    (ack_wr && !st_q.lvl_mode && !flag_set && !i_stop_wake) |=> !st_q.flag)
    else $error("acknowledge did not clear the flag");

  level_holds_a: assert property ( // [R12]
    (st_q.lvl_mode && (|en_asserted) && !i_stop_wake) |=> st_q.flag)
    else $error("asserted level failed to hold the flag");

  irq_follows_a: assert property ( // [R8]
    (st_q.flag && st_q.irq_en) |-> o_irq)
    else $error("interrupt not raised");

  ack_reads_zero_a: assert property ( // [R16]
    (rd_setup && i_paddr == `KBPI_OFF_STATUS) |=> (o_prdata[31:4] == 28'h0000000)
    && !o_prdata[`KBPI_BIT_ACK])
    else $error("status read shows unused bits");

  wake_reset_a: assert property ( // [R18]
    i_stop_wake |=> (st_q == '0))
    else $error("wake did not reset the unit");

  pull_sense_a: assert property ( // [R13]
    (o_pull_up & o_pull_down) == 8'h00)
    else $error("pullup and pulldown both on");

endmodule

`default_nettype wire

// File: common/kbpi_defines.svh
// Purpose : offsets, field positions, reset values of the key pin interrupt
// Assumes : apb byte addresses, one aligned 32-bit word per register
// Notes   : definitions only
`ifndef KBPI_DEFINES_SVH
`define KBPI_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define KBPI_ADDR_W       12
`define KBPI_OFF_STATUS   12'h000
`define KBPI_OFF_PIN_EN   12'h004
`define KBPI_OFF_POLARITY 12'h008
`define KBPI_OFF_PULL_EN  12'h00c
`define KBPI_OFF_EV_STAT  12'h010
`define KBPI_OFF_EV_CLR   12'h014
`define KBPI_OFF_EV_EN    12'h018

// ----------------------------------------------------------------------
// key_status_control field positions
// ----------------------------------------------------------------------
`define KBPI_BIT_LEVEL    0
`define KBPI_BIT_IRQ_EN   1
`define KBPI_BIT_ACK      2
`define KBPI_BIT_FLAG     3

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define KBPI_NPIN         8
`define KBPI_RST_BYTE     8'h00
`define KBPI_SYNC_STAGES  2

`endif

// File: common/kbpi_pkg.sv
// Purpose : types shared by the key pin interrupt files
// Assumes : kbpi_defines.svh on the include path
// Notes   : one packed struct holds all state of each module
`include "kbpi_defines.svh"
`default_nettype none

package kbpi_pkg;

  typedef logic [`KBPI_NPIN-1:0] kbpi_pins_t;

  // all state of the main block
  typedef struct packed {
    logic       flag;       // key_event_flag
    logic       irq_en;     // key_irq_enable
    logic       lvl_mode;   // level_sense_select
    kbpi_pins_t pin_en;     // pin_enable_reg
    kbpi_pins_t pol;        // polarity_select_reg
    kbpi_pins_t pull_en;    // port_pull_enable
    kbpi_pins_t prev_a;     // asserted sense seen last cycle
    kbpi_pins_t armed;      // deasserted level seen since enable
    kbpi_pins_t ev_stat;    // sticky per-pin edge events
    kbpi_pins_t ev_en;      // event interrupt enables
    logic [31:0] rdata;     // read data held for access phase
  } kbpi_state_t;

endpackage

`default_nettype wire

// File: common/kbpi_pin_if.sv
// Purpose : carries raw key pins into the synchroniser and back out
// Assumes : one clock domain
// Notes   : src side drives raw pins, snc side returns settled levels
`default_nettype none

interface kbpi_pin_if;
  kbpi_pkg::kbpi_pins_t raw;
  kbpi_pkg::kbpi_pins_t sync;

  modport src (output raw, input sync);
  modport snc (input raw, output sync);
endinterface

`default_nettype wire

// File: hdl/kbpi_sync.sv
// Purpose : two-stage synchroniser for the key pins
// Assumes : pins asynchronous to i_mclk
// Notes   : first stage feeds only the second stage
`include "kbpi_defines.svh"
`default_nettype none

module kbpi_sync
(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // pins
  kbpi_pin_if.snc   pins
);

  typedef struct packed {
    kbpi_pkg::kbpi_pins_t s1;
    kbpi_pkg::kbpi_pins_t s2;
  } kbpi_sync_st_t;

  kbpi_sync_st_t st_q;
  kbpi_sync_st_t st_d;

  // shift raw level through two flops
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pins.raw;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign pins.sync = st_q.s2;

endmodule

`default_nettype wire

// File: dv/kbpi_key_model.sv
// Purpose : switch bank facing the key pins, with the unit's pull resistors
// Assumes : bench sets drive enables and values just after a clock edge
// Notes   : a released pin with no pull shows the inverse of its last value
`default_nettype none

module kbpi_key_model
(
  // bench control
  input  wire logic [7:0] i_drv_en,
  input  wire logic [7:0] i_drv_val,
  // pull controls from the unit
  input  wire logic [7:0] i_pull_up,
  input  wire logic [7:0] i_pull_down,
  // pin levels
  output logic      [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // pin level
  // ------------------------------------------------------------------
  // a floating pin must not look like a stable level to the unit
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (i_drv_en[i])
        o_pin[i] = i_drv_val[i];
      else if (i_pull_up[i])
        o_pin[i] = 1'b1;
      else if (i_pull_down[i])
        o_pin[i] = 1'b0;
      else
        o_pin[i] = ~i_drv_val[i];
    end
  end
endmodule

`default_nettype wire

// File: dv/tb_top.sv
// Purpose : self-checking bench for the key pin interrupt unit
// Assumes : zero-wait apb slave, pins settle three edges after a change
// Notes   : random pins and polarities from a fixed seed
`include "kbpi_defines.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_wake = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, serr, irq;
  logic [7:0]  drv_en = 8'hff, drv_val = 8'hff, pu, pd, pins, r1, r2;
  logic [2:0]  k;
  logic        pol, lvl;
  int          n_fail = 0;
  int          cmp_count = 0;

  // 20 MHz bus clock
  always #25 i_mclk = ~i_mclk;

  kbpi_key_model i_kbpi_key_model (.i_drv_en(drv_en), .i_drv_val(drv_val),
    .i_pull_up(pu), .i_pull_down(pd), .o_pin(pins));

  kbpi_top i_kbpi_top (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_key_pin(pins),
    .i_stop_wake(stop_wake), .o_pull_up(pu), .o_pull_down(pd), .o_irq(irq));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] f_st(input logic fl, input logic ie, input logic lv);
    return {28'h0, fl, 1'b0, ie, lv};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // one apb transfer; held until pready is sampled high, only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_mclk);
    penable <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1)
      @(posedge i_mclk);
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge: the next setup never reassigns psel in this step, and
    // register outputs written at the access edge are settled for checks
    @(posedge i_mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  // ------------------------------------------------------------------
  // one pin, one polarity, one mode
  // ------------------------------------------------------------------
  task automatic pin_case();
    wr(`KBPI_OFF_STATUS, {31'h0, lvl}); // mask first
    wr(`KBPI_OFF_POLARITY, 32'h1 << k);
    wr(`KBPI_OFF_POLARITY, {24'h0, pol, 7'h0} >> (3'd7 - k));
    drv_val[k] <= pol; // start asserted
    wr(`KBPI_OFF_PIN_EN, 32'h1 << k);
    cyc(4);
    rd("no early edge", `KBPI_OFF_STATUS, f_st(lvl, 1'b0, lvl));
    wr(`KBPI_OFF_STATUS, {29'h0, 2'b10, lvl}); // drop any spurious flag
    rd("flag held", `KBPI_OFF_STATUS, f_st(lvl, 1'b0, lvl));
    drv_val[k] <= ~pol;
    cyc(5);
    wr(`KBPI_OFF_STATUS, {29'h0, 2'b10, lvl});
    wr(`KBPI_OFF_EV_CLR, 32'hff);
    wr(`KBPI_OFF_STATUS, {29'h0, 2'b01, lvl});
    drv_val <= drv_val ^ ~(8'h1 << k); // disabled pins toggle
    cyc(5);
    chk("irq idle", 32'h0, {31'h0, irq});
    drv_val[k] <= pol;
    cyc(5);
    chk("irq", 32'h1, {31'h0, irq});
    rd("flag set", `KBPI_OFF_STATUS, f_st(1'b1, 1'b1, lvl));
    wr(`KBPI_OFF_STATUS, {29'h0, 2'b11, lvl});
    rd("flag ack", `KBPI_OFF_STATUS, f_st(lvl, 1'b1, lvl));
    drv_val[k] <= ~pol;
    cyc(5);
    wr(`KBPI_OFF_STATUS, {29'h0, 2'b10, lvl});
    rd("flag clr", `KBPI_OFF_STATUS, f_st(1'b0, 1'b0, lvl));
    rd("ev stat", `KBPI_OFF_EV_STAT, 32'h1 << k);
    wr(`KBPI_OFF_EV_EN, 32'h1 << k);
    chk("ev irq", 32'h1, {31'h0, irq});
    wr(`KBPI_OFF_EV_EN, 32'h0);
    chk("ev mask", 32'h0, {31'h0, irq});
    wr(`KBPI_OFF_EV_EN, 32'h1 << k);
    wr(`KBPI_OFF_EV_CLR, 32'h1 << k);
    chk("ev clr", 32'h0, {31'h0, irq});
    rd("ev stat clr", `KBPI_OFF_EV_STAT, 32'h0);
    wr(`KBPI_OFF_EV_EN, 32'h0);
    wr(`KBPI_OFF_PIN_EN, 32'h0);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    void'($urandom(73));
    cyc(2);
    i_nrst <= 1'b1;
    cyc(1);
    for (int a = 0; a < 7; a++)
      rd("reset", 12'(4 * a), 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, serr});
    chk("unmapped data", 32'h0, rdat);
    wr(`KBPI_OFF_STATUS, 32'hffffffff);
    rd("status bits", `KBPI_OFF_STATUS, f_st(1'b0, 1'b1, 1'b1));
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    wr(`KBPI_OFF_POLARITY, {24'h0, r1});
    wr(`KBPI_OFF_PULL_EN, {24'h0, r2});
    chk("pull up", {24'h0, r2 & ~r1}, {24'h0, pu});
    chk("pull down", {24'h0, r2 & r1}, {24'h0, pd});
    stop_wake <= 1'b1;
    cyc(1);
    stop_wake <= 1'b0;
    cyc(1);
    rd("wake pull", `KBPI_OFF_PULL_EN, 32'h0);
    rd("wake status", `KBPI_OFF_STATUS, 32'h0);
    drv_val <= 8'($urandom);
    for (int i = 0; i < 6; i++)
    begin
      k   = (i == 0) ? 3'd0 : (i == 1) ? 3'd7 : 3'($urandom);
      pol = i[0];
      lvl = i[1];
      pin_case();
    end
    report_and_stop();
  end

  // hang guard, far beyond the roughly 600 cycles the run needs
  initial
  begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
endmodule

`default_nettype wire
